/* File: hw/sarc_device.sv */
`include "sarc_defines.svh"
// converter control end
module sarc_device
(
	input wire logic clock,
	input wire logic rstn,
	sarc_if.device link,
	input wire logic [11:0] sample_code,
	output logic holding,
	output logic asleep
);
	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	// true while the machine is in the converting state
	function automatic logic is_converting(input sarc_pkg::sarc_dev_state_type s);
		is_converting = (s == sarc_pkg::dev_conv);
	endfunction : is_converting
	// true while the machine waits for a start edge
	function automatic logic is_idle(input sarc_pkg::sarc_dev_state_type s);
		is_idle = (s == sarc_pkg::dev_idle);
	endfunction : is_idle
	// true while the machine rests in sleep
	function automatic logic is_sleeping(input sarc_pkg::sarc_dev_state_type s);
		is_sleeping = (s == sarc_pkg::dev_sleep);
	endfunction : is_sleeping
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [3:0] pin_raw; // pin levels: start, clock, select, read
	logic [3:0] pin_sync; // the same pins after two flip-flops
	logic start_s; // synchronised start
	logic start_d; // previous start
	logic cclk_s; // synchronised conversion clock
	logic cclk_d; // previous conversion clock
	logic cs_s; // synchronised select
	logic rd_s; // synchronised read
	logic [3:0] cycles; // conversion clock rises counted
	logic [11:0] result_reg; // output register
	sarc_pkg::sarc_dev_state_type state; // converter state
	logic start_fall; // start strobe seen falling
	logic cclk_rise; // conversion clock seen rising
	logic last_cycle; // final counted rise of a conversion
	logic track_early; // rise after which track/hold returns to track
	logic enable_n; // output enable, active low
	// ----------------------------------------
	// edge and end-of-conversion decode
	// ----------------------------------------
	assign start_fall = start_d & ~start_s;
	// both history and synchroniser rest high, so no false rise after reset
	assign cclk_rise = cclk_s & ~cclk_d;
	assign last_cycle = is_converting(state) && cclk_rise
		&& (cycles == `SARC_CONV_CYCLES - 4'h1);
	assign track_early = is_converting(state) && cclk_rise
		&& (cycles == `SARC_CONV_CYCLES - 4'h2);
	// one or gate: both strobes must be low to enable
	assign enable_n = cs_s | rd_s;
	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	// pins gathered so one loop builds every chain
	assign pin_raw[0] = link.conversion_start_n;
	assign pin_raw[1] = link.conv_clock;
	assign pin_raw[2] = link.chip_select_n;
	assign pin_raw[3] = link.read_n;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_sync
			// each pin passes two flip-flops before logic reads it
			sarc_sync u_sarc_sync (.clock(clock), .rstn(rstn), .din(pin_raw[gi]),
				.dout(pin_sync[gi]));
		end
	endgenerate
	// synchronised pins under their own names
	assign start_s = pin_sync[0];
	assign cclk_s = pin_sync[1];
	assign cs_s = pin_sync[2];
	assign rd_s = pin_sync[3];
	// ----------------------------------------
	// edge history
	// ----------------------------------------
	// history resets to the synchroniser's reset level to avoid a false edge
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			start_d <= 1'b1;
			cclk_d <= 1'b1;
		end
		else
		begin
			start_d <= start_s;
			cclk_d <= cclk_s;
		end
	end
	// ----------------------------------------
	// conversion state machine
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (!rstn)
			state <= sarc_pkg::dev_idle;
		else
			case (state)
				sarc_pkg::dev_idle:
					if (start_fall)
						state <= sarc_pkg::dev_conv;
				sarc_pkg::dev_conv:
					if (last_cycle)
						// still low at end: sleep
						state <= start_s ? sarc_pkg::dev_idle : sarc_pkg::dev_sleep;
				sarc_pkg::dev_sleep:
					if (start_s)
						state <= sarc_pkg::dev_idle; // rising edge wakes
				default:
					state <= sarc_pkg::dev_idle;
			endcase
	end
	// ----------------------------------------
	// conversion clock counter
	// ----------------------------------------
	// conversion clock counted only while converting
	// outside a conversion the clock is ignored, so idle toggling costs nothing
	always_ff @(posedge clock)
	begin
		if (!rstn)
			cycles <= 4'h0;
		else if (!is_converting(state))
			cycles <= 4'h0;
		else if (cclk_rise)
			cycles <= cycles + 4'h1;
	end
	// ----------------------------------------
	// output register
	// ----------------------------------------
	// result loaded at end, held otherwise; straight binary
	// repeated reads between conversions therefore return the same code
	always_ff @(posedge clock)
	begin
		if (!rstn)
			result_reg <= 12'h000;
		else if (last_cycle)
			result_reg <= sample_code;
	end
	// ----------------------------------------
	// outputs
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			link.busy <= 1'b0;
			holding <= 1'b0;
			asleep <= 1'b0;
		end
		else
		begin
			// busy high whole conversion, drops on the load edge
			link.busy <= is_idle(state) ? start_fall
				: is_converting(state) && !last_cycle;
			// hold from start; track one conversion clock before busy falls
			if (is_idle(state))
				holding <= start_fall;
			else if (track_early || last_cycle)
				holding <= 1'b0; // back to tracking ahead of busy
			else
				holding <= holding && is_converting(state);
			// asleep drops as soon as the wake edge is seen
			asleep <= is_sleeping(state) && !start_s;
		end
	end
	// ----------------------------------------
	// result bus drive
	// ----------------------------------------
	// bus driven only with both strobes low; tied low stays driven
	// the new code goes out on the load edge, so a tied-low bus shows it with busy
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			link.result_oe <= 1'b0;
			link.result_out <= 12'h000;
		end
		else
		begin
			link.result_oe <= !enable_n;
			link.result_out <= last_cycle ? sample_code : result_reg;
		end
	end
endmodule : sarc_device

/* File: hw/sarc_defines.svh */
`ifndef SARC_DEFINES_SVH
`define SARC_DEFINES_SVH
// ----------------------------------------
// widths and timing
// ----------------------------------------
`define SARC_RESULT_W 12
`define SARC_CONV_CYCLES 4'hE
`define SARC_CLK_NS 40
`define SARC_START_PULSE_NS 10
`define SARC_START_PULSE_CYC ((`SARC_START_PULSE_NS + `SARC_CLK_NS - 1) / `SARC_CLK_NS)
`define SARC_WAKE_NS 1000
`define SARC_WAKE_CYC ((`SARC_WAKE_NS + `SARC_CLK_NS - 1) / `SARC_CLK_NS)
`define SARC_CCLK_HALF 4'h2
`endif

/* File: hw/sarc_pkg.sv */
package sarc_pkg;
	// ----------------------------------------
	// device converter states
	// ----------------------------------------
	typedef enum logic [1:0] {dev_idle, dev_conv, dev_sleep} sarc_dev_state_type;
	// ----------------------------------------
	// host sequencer states
	// ----------------------------------------
	typedef enum logic [2:0] {hst_idle, hst_start, hst_wait, hst_read, hst_wake} sarc_host_state_type;
endpackage : sarc_pkg

/* File: hw/sarc_if.sv */
interface sarc_if;
	logic conversion_start_n; // start strobe, from host
	logic conv_clock; // conversion clock level, from host
	logic chip_select_n; // chip select, from host
	logic read_n; // read strobe, from host
	logic busy; // conversion in progress, from device
	logic [11:0] result_out; // result bus drive value
	logic result_oe; // high while device drives result bus
	logic [11:0] result_bus; // resolved bus level
	assign result_bus = result_oe ? result_out : 12'hFFF;
	modport device (input conversion_start_n, input conv_clock, input chip_select_n,
		input read_n, output busy, output result_out, output result_oe);
	modport host (output conversion_start_n, output conv_clock, output chip_select_n,
		output read_n, input busy, input result_bus);
endinterface : sarc_if

/* File: hw/sarc_sync.sv */
// two-flop synchroniser for pin inputs
module sarc_sync
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic din,
	output logic dout
);
	logic stage1; // first stage, read only by dout
	// ----------------------------------------
	// synchroniser chain, resets high (idle)
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			stage1 <= 1'b1;
			dout <= 1'b1;
		end
		else
		begin
			stage1 <= din;
			dout <= stage1;
		end
	end
endmodule : sarc_sync

/* File: hw/sarc_host.sv */
`include "sarc_defines.svh"
// host end: starts conversions, clocks them, reads results
module sarc_host
(
	input wire logic clock,
	input wire logic rstn,
	sarc_if.host link,
	input wire logic go,
	input wire logic auto_sleep,
	output logic [11:0] data,
	output logic data_valid
);
	logic busy_s; // synchronised busy
	logic busy_d; // previous busy
	logic [11:0] bus_m; // bus first stage
	logic [11:0] bus_s; // bus second stage
	logic [3:0] div; // conversion clock divider
	logic [5:0] timer; // pulse and wake timer
	sarc_pkg::sarc_host_state_type state;
	sarc_sync u_busy (.clock(clock), .rstn(rstn), .din(link.busy), .dout(busy_s));
	// ----------------------------------------
	// bus synchroniser and busy history
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			bus_m <= 12'h000;
			bus_s <= 12'h000;
			busy_d <= 1'b0;
		end
		else
		begin
			bus_m <= link.result_bus;
			bus_s <= bus_m;
			busy_d <= busy_s;
		end
	end
	// conversion clock 25 MHz / 4 = 6.25 MHz, inside range
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			div <= 4'h0;
			link.conv_clock <= 1'b0;
		end
		else if (div == `SARC_CCLK_HALF - 4'h1)
		begin
			div <= 4'h0;
			link.conv_clock <= ~link.conv_clock;
		end
		else
			div <= div + 4'h1;
	end
	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			state <= sarc_pkg::hst_idle;
			timer <= 6'h00;
			link.conversion_start_n <= 1'b1;
			link.chip_select_n <= 1'b1;
			link.read_n <= 1'b1;
			data <= 12'h000;
			data_valid <= 1'b0;
		end
		else
		begin
			data_valid <= 1'b0;
			case (state)
				sarc_pkg::hst_idle:
					if (go && !busy_s)
					begin
						link.conversion_start_n <= 1'b0;
						timer <= 6'h00;
						state <= sarc_pkg::hst_start;
					end
				sarc_pkg::hst_start:
				begin
					timer <= timer + 6'h01;
					// low at least the least pulse width
					if (timer >= 6'(`SARC_START_PULSE_CYC) - 6'h01 && busy_s)
					begin
						if (!auto_sleep)
							link.conversion_start_n <= 1'b1;
						state <= sarc_pkg::hst_wait;
					end
				end
				sarc_pkg::hst_wait:
					if (busy_d && !busy_s)
					begin
						link.chip_select_n <= 1'b0;
						link.read_n <= 1'b0;
						timer <= 6'h00;
						state <= sarc_pkg::hst_read;
					end
				sarc_pkg::hst_read:
				begin
					timer <= timer + 6'h01;
					// bus needs three edges to drive plus two synchroniser stages
					if (timer == 6'h05)
					begin
						data <= bus_s;
						data_valid <= 1'b1;
						link.chip_select_n <= 1'b1;
						link.read_n <= 1'b1;
						link.conversion_start_n <= 1'b1; // wake if asleep
						timer <= 6'h00;
						state <= auto_sleep ? sarc_pkg::hst_wake : sarc_pkg::hst_idle;
					end
				end
				sarc_pkg::hst_wake:
				begin
					timer <= timer + 6'h01;
					if (timer == 6'(`SARC_WAKE_CYC) - 6'h01)
						state <= sarc_pkg::hst_idle; // wake-up time elapsed
				end
				default:
					state <= sarc_pkg::hst_idle;
			endcase
		end
	end
endmodule : sarc_host

/* File: bench/sarc_properties.sv */
// watches the link between host and converter ends
module sarc_properties
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic conversion_start_n,
	input wire logic conv_clock,
	input wire logic chip_select_n,
	input wire logic read_n,
	input wire logic busy,
	input wire logic [11:0] result_out,
	input wire logic result_oe
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rstn);
	logic [4:0] rises; // conversion clock rises within one busy period
	logic cclk_m; // conversion clock, first stage as the converter sees it
	logic cclk_q; // conversion clock, second stage as the converter sees it
	// ----------------------------------------
	// helper: conversion clock delayed like the converter's own view
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		cclk_m <= conv_clock;
		cclk_q <= cclk_m;
	end
	// ----------------------------------------
	// helper: count clock rises while busy
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (!rstn || !busy)
			rises <= 5'h00;
		else if ($rose(cclk_q))
			rises <= rises + 5'h01;
	end
	// strobes held low long enough to reach the bus
	sequence s_both_low;
		(!chip_select_n && !read_n) [*4];
	endsequence
	// either strobe held high long enough to release the bus
	sequence s_either_high;
		(chip_select_n || read_n) [*4];
	endsequence
	a_oe_needs_strobes: assert property (result_oe |-> $past(!chip_select_n && !read_n, 3))
		else $error("bus driven without both strobes low");
	a_oe_follows_strobes: assert property (s_both_low |-> result_oe)
		else $error("bus not driven after both strobes low");
	a_oe_releases: assert property (s_either_high |-> !result_oe)
		else $error("bus still driven after strobe release");
	a_busy_after_start: assert property ($fell(conversion_start_n) && !busy |-> ##[1:4] busy)
		else $error("busy late after start fall");
	a_busy_cause: assert property ($rose(busy) |-> !conversion_start_n)
		else $error("busy rose without start low");
	a_busy_holds: assert property ($rose(busy) |=> busy [*8])
		else $error("busy dropped early");
	a_conv_length: assert property ($fell(busy) |-> rises == 5'h0E)
		else $error("conversion not fourteen clocks long");
	a_result_held: assert property (!$fell(busy) |-> $stable(result_out))
		else $error("result changed outside conversion end");
endmodule : sarc_properties

/* File: bench/tb_top.sv */
// host and converter ends joined, driven from the host user side
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock;
	logic rstn;
	logic go; // conversion request
	logic auto_sleep; // keep start low through conversion
	logic [11:0] sample_code; // code the converter will produce
	logic [11:0] data;
	logic data_valid;
	logic holding;
	logic asleep;
	int failures;
	int comparisons;
	int cycles;
	logic [11:0] codes [6] = '{12'h000, 12'hFFF, 12'hA5C, 12'h5A3, 12'h800, 12'h001};
	sarc_if link();
	sarc_device u_sarc_device (.clock(clock), .rstn(rstn), .link(link),
		.sample_code(sample_code), .holding(holding), .asleep(asleep));
	sarc_host u_sarc_host (.clock(clock), .rstn(rstn), .link(link), .go(go),
		.auto_sleep(auto_sleep), .data(data), .data_valid(data_valid));
	sarc_properties u_sarc_properties (.clock(clock), .rstn(rstn),
		.conversion_start_n(link.conversion_start_n), .conv_clock(link.conv_clock),
		.chip_select_n(link.chip_select_n), .read_n(link.read_n), .busy(link.busy),
		.result_out(link.result_out), .result_oe(link.result_oe));
	// ----------------------------------------
	// clock and hang guard
	// ----------------------------------------
	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			failures++;
			give_verdict();
		end
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : tick
	task automatic compare(input logic [11:0] seen, input logic [11:0] want);
		comparisons++;
		if (seen !== want)
		begin
			failures++;
			$display("Error at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask : compare
	// one conversion and read through the host end
	task automatic convert(input logic [11:0] code, input logic sleep);
		int i;
		sample_code = code;
		auto_sleep = sleep;
		go = 1'b1;
		for (i = 0; i < 20 && link.busy !== 1'b1; i++)
			tick(1);
		compare(holding, 12'h001);
		compare(link.busy, 12'h001);
		for (i = 0; i < 200 && data_valid !== 1'b1; i++)
			tick(1);
		go = 1'b0;
		compare(data, code);
		compare(asleep, sleep);
		compare(holding, 12'h000);
		tick(30);
		compare(link.result_bus, 12'hFFF);
		compare(asleep, 12'h000);
		compare(link.busy, 12'h000);
		$display("test code %h sleep %0d done", code, sleep);
	endtask : convert
	task give_verdict;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		go = 1'b0;
		auto_sleep = 1'b0;
		sample_code = 12'h000;
		rstn = 1'b0;
		tick(3);
		rstn = 1'b1;
		tick(4);
		for (int k = 0; k < 6; k++)
			convert(codes[k], (k == 2 || k == 3 || k == 4));
		// second reset in mid-run, then one more conversion
		rstn = 1'b0;
		tick(3);
		rstn = 1'b1;
		tick(4);
		compare(link.busy, 12'h000);
		convert(12'h3C7, 1'b0);
		give_verdict();
	end
endmodule : tb_top
